/* shared/bsr_pkg.sv */
// Package: constants and types of the barometric sensor serial readout
package bsr_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned MCLK_HZ        = 25_000_000;
	localparam int unsigned CONV_TIME_MS   = 35;
	localparam int unsigned CONV_CYCLES    =
		(MCLK_HZ / 1000) * CONV_TIME_MS;
	localparam int unsigned CONV_TICK_DIV  = 763;
	localparam int unsigned CONV_TICKS     = 1140;
	localparam int unsigned BRIDGE_ON_TICKS = 65;
	// Weight per modulator one: arbitrary, odd so every bit can move
	localparam logic [15:0] ADC_STEP       = 16'h03EF;

	// ************************************************************
	// Framing
	// ************************************************************
	localparam int unsigned START_BITS     = 3;
	localparam int unsigned SETUP_BITS     = 4;
	localparam int unsigned STOP_BITS      = 3;
	localparam int unsigned FRAME_BITS     =
		START_BITS + SETUP_BITS + STOP_BITS;
	localparam int unsigned WORD_BITS      = 16;
	localparam int unsigned ACK_CLOCKS     = 2;
	localparam int unsigned READ_CLOCKS    = 17;
	localparam int unsigned RESET_BITS     = 21;
	localparam logic [9:0] FRAME_MASK      = 10'h387;
	localparam logic [9:0] FRAME_MARK      = 10'h380;

	// ************************************************************
	// Instruction codes and reset pattern
	// ************************************************************
	localparam logic [3:0]  SETUP_PRESS    = 4'hA;
	localparam logic [3:0]  SETUP_TEMP     = 4'h9;
	localparam logic [3:0]  SETUP_CAL_A    = 4'h5;
	localparam logic [3:0]  SETUP_CAL_B    = 4'h6;
	localparam logic [3:0]  SETUP_CAL_C    = 4'h3;
	localparam logic [3:0]  SETUP_CAL_D    = 4'hC;
	localparam logic [20:0] RESET_PATTERN  = 21'h155540;

	// ************************************************************
	// Calibration store reset values
	// ************************************************************
	localparam logic [15:0] CALIB_A_INIT   = 16'h1234;
	localparam logic [15:0] CALIB_B_INIT   = 16'h5678;
	localparam logic [15:0] CALIB_C_INIT   = 16'h9ABC;
	localparam logic [15:0] CALIB_D_INIT   = 16'hDEF0;

	typedef enum logic [5:0] {
		BSR_IDLE = 6'h01,
		BSR_ACK  = 6'h02,
		BSR_CONV = 6'h04,
		BSR_DONE = 6'h08,
		BSR_SEND = 6'h10,
		BSR_RCAL = 6'h20
	} bsr_state_t;

endpackage : bsr_pkg

/* shared/bsr_stream_if.sv */
// Interface: word stream between converter and output shifter
`timescale 1ns/10ps
interface bsr_stream_if #(
	parameter int unsigned WIDTH = 16
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src  (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : bsr_stream_if

/* core/bsr_fifo.sv */
// Module: parameterised word FIFO with valid and ready on both sides
`timescale 1ns/10ps
module bsr_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic  mclk_in,    // System clock
	input  wire logic  sys_rst_in, // Synchronous reset
	input  wire logic  flush_in,   // Drop all words
	bsr_stream_if.sink wr,         // Filling side
	bsr_stream_if.src  rd          // Draining side
);
	import bsr_pkg::*;

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("bsr_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} bsr_fifo_st_t;

	bsr_fifo_st_t     s_q;
	bsr_fifo_st_t     s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic             full;
	logic             empty;

	assign empty    = (s_q.wp == s_q.rp);
	assign full     = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) &&
		(s_q.wp[AW] != s_q.rp[AW]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem_q[s_q.rp[AW-1:0]];

	always_comb begin
		s_d = s_q;
		if (wr.valid && !full)
			s_d.wp = s_q.wp + 1'b1;
		if (rd.ready && !empty)
			s_d.rp = s_q.rp + 1'b1;
		if (flush_in)
			s_d.rp = s_d.wp;
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
		if (wr.valid && !full)
			mem_q[s_q.wp[AW-1:0]] <= wr.data;
	end

endmodule : bsr_fifo

/* core/bsr_conv.sv */
// Module: conversion sequencer with bridge power and sigma-delta sampling
`timescale 1ns/10ps
module bsr_conv #(
	parameter int unsigned TICK_DIV = bsr_pkg::CONV_TICK_DIV
) (
	input  wire logic  mclk_in,      // System clock
	input  wire logic  sys_rst_in,   // Synchronous reset
	input  wire logic  start_in,     // Start pulse
	input  wire logic  sel_temp_in,  // 1: temperature, 0: pressure
	input  wire logic  abort_in,     // Serial reset seen
	input  wire logic  mod_bit_in,   // Synchronised modulator bit
	output logic       busy_out,     // Conversion running or result pending
	output logic       bridge_on_out, // Bridge supply on
	output logic       adc_sel_out,  // Shared ADC input select
	bsr_stream_if.src  res           // Result word out
);
	import bsr_pkg::*;

	initial begin
		if (TICK_DIV < 1 || TICK_DIV * CONV_TICKS > CONV_CYCLES)
			$error("bsr_conv: conversion would exceed its time");
	end

	typedef struct packed {
		logic        busy;
		logic        sel;
		logic        pend;
		logic [15:0] div;
		logic [10:0] tick;
		logic [15:0] acc;
	} bsr_conv_st_t;

	bsr_conv_st_t s_q;
	bsr_conv_st_t s_d;
	logic         tick_en;

	assign tick_en       = s_q.busy && (s_q.div == 16'(TICK_DIV - 1));
	assign busy_out      = s_q.busy || s_q.pend;
	assign adc_sel_out   = s_q.sel;                          // R19
	assign bridge_on_out = s_q.busy &&
		(s_q.tick < 11'(BRIDGE_ON_TICKS));                   // R20
	assign res.valid     = s_q.pend;
	assign res.data      = s_q.acc;

	always_comb begin
		s_d = s_q;
		if (s_q.busy) begin
			s_d.div = tick_en ? '0 : s_q.div + 16'h0001;
			// Integrate only while the bridge is powered
			if (tick_en && bridge_on_out && mod_bit_in)
				s_d.acc = s_q.acc + ADC_STEP;            // R19
			if (tick_en) begin
				s_d.tick = s_q.tick + 11'h001;
				if (s_q.tick == 11'(CONV_TICKS - 1)) begin
					s_d.busy = 1'b0;                     // R21
					s_d.pend = 1'b1;
				end
			end
		end else if (start_in && !s_q.pend) begin
			s_d.busy = 1'b1;
			s_d.sel  = sel_temp_in;
			s_d.div  = '0;
			s_d.tick = '0;
			s_d.acc  = '0;
		end
		if (s_q.pend && res.ready)
			s_d.pend = 1'b0;
		if (abort_in) begin
			s_d.busy = 1'b0;
			s_d.pend = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule : bsr_conv

/* core/bsr_top.sv */
// Module: serial readout and command logic of the barometric sensor
//
// Function
// R1: Input bit is captured at each rising serial clock edge.
// R2: Output bit changes at each rising serial clock edge.
// R3: Host samples output and changes input on falling edges.
// R4: Host makes the serial clock; device never drives it.
// R5: Output returns conversion result or calibration word per instruction.
// R6: Every transaction opens with an instruction; no chip select.
// R7: Setup field framed by three high start and three low stop bits.
// R8: Four-bit setup selects pressure, temperature or one calibration word.
// R9: Conversion start acknowledged by output going low to high.
// R10: Host gives exactly two clocks after the acknowledge.
// R11: Clock held low during conversion; output falls at completion.
// R12: Seventeen clocks after completion shift out the 16-bit result.
// R13: Readout may pause on held clock; position is kept.
// R14: Host reads the pending result before starting a new conversion.
// R15: A 21-bit reset pattern resynchronises the interface from any state.
// R16: Host ignores the output line during the reset pattern.
// R17: Host should send the reset pattern before each conversion.
// R18: 64 calibration bits read as four 16-bit words.
// R19: One shared ADC gives 16-bit pressure and temperature values.
// R20: Bridge powered only briefly within each measurement.
// R21: Conversion finishes within 35 ms.
// R22: Master clock may stop in standby with no conversion.
// R23: Instruction and reset patterns are design parameters.
`timescale 1ns/10ps
module bsr_top #(
	parameter logic [3:0]  CMD_PRESS   = bsr_pkg::SETUP_PRESS,
	parameter logic [3:0]  CMD_TEMP    = bsr_pkg::SETUP_TEMP,
	parameter logic [3:0]  CMD_CAL_A   = bsr_pkg::SETUP_CAL_A,
	parameter logic [3:0]  CMD_CAL_B   = bsr_pkg::SETUP_CAL_B,
	parameter logic [3:0]  CMD_CAL_C   = bsr_pkg::SETUP_CAL_C,
	parameter logic [3:0]  CMD_CAL_D   = bsr_pkg::SETUP_CAL_D,
	parameter logic [20:0] RST_PATTERN = bsr_pkg::RESET_PATTERN, // R23
	parameter int unsigned TICK_DIV    = bsr_pkg::CONV_TICK_DIV,
	parameter int unsigned FIFO_DEPTH  = 8
) (
	input  wire logic        mclk_in,       // 25 MHz system clock
	input  wire logic        sys_rst_in,    // Synchronous reset, high
	input  wire logic        sclk_in,       // Host serial clock pin
	input  wire logic        din_in,        // Serial data input pin
	input  wire logic        mod_bit_in,    // Modulator comparator bit
	output logic             dout_out,      // Serial data output pin
	output logic             bridge_on_out, // Sensor bridge supply
	output logic             adc_sel_out,   // 1: temperature input
	output logic             conv_busy_out, // Conversion or result held
	output logic [15:0]      raw_pressure_value_out,    // Last pressure
	output logic [15:0]      raw_temperature_value_out  // Last temperature
);
	import bsr_pkg::*;

	initial begin
		if (FIFO_DEPTH < 2)
			$error("bsr_top: FIFO_DEPTH must be at least 2");
		if (CMD_PRESS == CMD_TEMP)
			$error("bsr_top: conversion codes must differ");
	end

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic [1:0] sclk_sync_q;
	logic [1:0] din_sync_q;
	logic [1:0] mod_sync_q;
	logic       sclk_prev_q;
	logic       sclk_rise;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sclk_sync_q <= 2'h0;
			din_sync_q  <= 2'h0;
			mod_sync_q  <= 2'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_sync_q <= {sclk_sync_q[0], sclk_in};
			din_sync_q  <= {din_sync_q[0], din_in};
			mod_sync_q  <= {mod_sync_q[0], mod_bit_in};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	// Host clock is sampled, so the device follows at most ~120 ns late
	assign sclk_rise = sclk_sync_q[1] && !sclk_prev_q;             // R4

	// ************************************************************
	// State record
	// ************************************************************
	typedef struct packed {
		bsr_state_t  st;
		logic [9:0]  frame;
		logic [3:0]  fcnt;
		logic [20:0] rst_sh;
		logic [4:0]  cnt;
		logic [16:0] shift;
		logic        dout;
		logic        conv_temp;
		logic [15:0] press;
		logic [15:0] temp;
		logic [63:0] calib;
	} bsr_st_t;

	bsr_st_t s_q;
	bsr_st_t s_d;

	// ************************************************************
	// Converter and result buffer
	// ************************************************************
	bsr_stream_if #(.WIDTH(WORD_BITS)) conv_res ();
	bsr_stream_if #(.WIDTH(WORD_BITS)) buf_out ();

	logic conv_start;
	logic serial_reset;
	logic conv_busy;

	bsr_conv #(
		.TICK_DIV      (TICK_DIV)
	) u_conv (
		.mclk_in       (mclk_in),
		.sys_rst_in    (sys_rst_in),
		.start_in      (conv_start),
		.sel_temp_in   (s_q.conv_temp),
		.abort_in      (serial_reset),
		.mod_bit_in    (mod_sync_q[1]),
		.busy_out      (conv_busy),
		.bridge_on_out (bridge_on_out),
		.adc_sel_out   (adc_sel_out),
		.res           (conv_res.src)
	);

	bsr_fifo #(
		.WIDTH      (WORD_BITS),
		.DEPTH      (FIFO_DEPTH)
	) u_fifo (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.flush_in   (serial_reset),
		.wr         (conv_res.sink),
		.rd         (buf_out.src)
	);

	// ************************************************************
	// Command decode and serial sequencing
	// ************************************************************
	logic [20:0] rst_next;
	logic [9:0]  frame_next;
	logic        frame_ok;
	logic [3:0]  setup;

	assign rst_next   = {s_q.rst_sh[19:0], din_sync_q[1]};         // R1
	assign frame_next = {s_q.frame[8:0], din_sync_q[1]};
	assign setup      = frame_next[6:3];
	assign frame_ok   = s_q.fcnt >= 4'(FRAME_BITS - 1) &&
		((frame_next & FRAME_MASK) == FRAME_MARK);                  // R7
	assign serial_reset = sclk_rise && (rst_next == RST_PATTERN);  // R15
	assign conv_start = (s_q.st == BSR_ACK) && (s_q.cnt == 5'h00) &&
		!conv_busy_out;
	assign buf_out.ready = (s_q.st == BSR_DONE) && buf_out.valid &&
		sclk_rise;

	always_comb begin
		s_d = s_q;
		if (sclk_rise) begin
			s_d.rst_sh = rst_next;
			s_d.frame  = frame_next;
			if (s_q.fcnt != 4'(FRAME_BITS))
				s_d.fcnt = s_q.fcnt + 4'h1;
		end
		case (s_q.st)
			BSR_IDLE: begin
				// Last result bit stands until the host clocks again
				if (sclk_rise)
					s_d.dout = 1'b0;
				if (sclk_rise && frame_ok) begin                      // R6
					s_d.fcnt = '0;
					s_d.cnt  = '0;
					if (setup == CMD_PRESS || setup == CMD_TEMP) begin // R8
						s_d.conv_temp = (setup == CMD_TEMP);
						s_d.st        = BSR_ACK;
					end else if (setup == CMD_CAL_A) begin       // R18
						s_d.shift = {1'b0, s_q.calib[63:48]};
						s_d.st    = BSR_RCAL;
					end else if (setup == CMD_CAL_B) begin
						s_d.shift = {1'b0, s_q.calib[47:32]};
						s_d.st    = BSR_RCAL;
					end else if (setup == CMD_CAL_C) begin
						s_d.shift = {1'b0, s_q.calib[31:16]};
						s_d.st    = BSR_RCAL;
					end else if (setup == CMD_CAL_D) begin
						s_d.shift = {1'b0, s_q.calib[15:0]};
						s_d.st    = BSR_RCAL;
					end
				end
			end
			BSR_ACK: begin
				// Stray result still held: wait; it cannot be read here, only a serial reset clears it
				if (s_q.cnt == 5'h00 && !conv_busy_out) begin        // R14
					s_d.dout = 1'b1;                              // R9
					s_d.cnt  = 5'h01;
				end else if (s_q.cnt != 5'h00 && sclk_rise) begin
					s_d.cnt = s_q.cnt + 5'h01;                    // R10
					if (s_q.cnt == 5'(ACK_CLOCKS))
						s_d.st = BSR_CONV;
				end
			end
			BSR_CONV: begin
				if (buf_out.valid) begin                          // R11
					s_d.dout = 1'b0;
					s_d.cnt  = '0;
					s_d.st   = BSR_DONE;
				end
			end
			BSR_DONE: begin
				if (buf_out.ready) begin                          // R5
					s_d.shift = {1'b0, buf_out.data};
					if (s_q.conv_temp)
						s_d.temp  = buf_out.data;
					else
						s_d.press = buf_out.data;
					s_d.dout = 1'b0;
					s_d.cnt  = 5'h01;
					s_d.st   = BSR_SEND;
				end
			end
			BSR_SEND, BSR_RCAL: begin
				// Held clock simply freezes the counter and shifter
				if (sclk_rise) begin                              // R13
					s_d.dout  = s_q.shift[15];                   // R2
					s_d.shift = {s_q.shift[15:0], 1'b0};
					s_d.cnt   = s_q.cnt + 5'h01;
					if (s_q.cnt == 5'(READ_CLOCKS - 1)) begin    // R12
						s_d.fcnt = '0;
						s_d.st   = BSR_IDLE;
					end
				end
			end
			default: s_d.st = BSR_IDLE;
		endcase
		if (serial_reset) begin                                   // R15
			s_d.st   = BSR_IDLE;
			s_d.dout = 1'b0;
			s_d.fcnt = '0;
			s_d.cnt  = '0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_q       <= '0;
			s_q.st    <= BSR_IDLE;
			s_q.calib <= {CALIB_A_INIT, CALIB_B_INIT,
				CALIB_C_INIT, CALIB_D_INIT};                     // R18
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign dout_out                  = s_q.dout;
	// A result waiting in the buffer still counts as pending
	assign conv_busy_out             = conv_busy || buf_out.valid;
	assign raw_pressure_value_out    = s_q.press;
	assign raw_temperature_value_out = s_q.temp;

endmodule : bsr_top

/* tb/bsr_top_properties.sv */
// Checker: port-level properties of the serial readout block
`timescale 1ns/10ps
module bsr_top_properties
	import bsr_pkg::*;
#(
	parameter int unsigned TICK_DIV = CONV_TICK_DIV
) (
	input wire logic        mclk_in,                   // System clock
	input wire logic        sys_rst_in,                // Sync reset
	input wire logic        sclk_in,                   // Serial clock
	input wire logic        din_in,                    // Serial data in
	input wire logic        mod_bit_in,                // Modulator bit
	input wire logic        dout_out,                  // Serial data out
	input wire logic        bridge_on_out,             // Bridge supply
	input wire logic        adc_sel_out,               // ADC select
	input wire logic        conv_busy_out,             // Busy level
	input wire logic [15:0] raw_pressure_value_out,    // Last pressure
	input wire logic [15:0] raw_temperature_value_out  // Last temperature
);
	localparam int unsigned BR_MAX = (BRIDGE_ON_TICKS + 1) * TICK_DIV;
	localparam int unsigned CV_MAX = CONV_TICKS * TICK_DIV + 400;
	logic [7:0]  idle_q;
	logic [15:0] bon_q;
	logic [19:0] dhi_q;
	// Run-length counters; long holds are checked on these, not repeats
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || sclk_in)
			idle_q <= 8'h00;
		else if (idle_q != 8'hFF)
			idle_q <= idle_q + 8'h01;
		bon_q <= (bridge_on_out && !sys_rst_in) ? bon_q + 16'h0001 : 16'h0000;
		dhi_q <= (dout_out && !sys_rst_in) ? dhi_q + 20'h00001 : 20'h00000;
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence rst_release;
		sys_rst_in ##1 !sys_rst_in;
	endsequence
	sequence sclk_idle;
		idle_q >= 8'h08;
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0)
		rst_release |-> !dout_out && !bridge_on_out && !conv_busy_out)
		else $error("outputs not quiet after reset");
	bridge_idle_a: assert property (!conv_busy_out |-> !bridge_on_out)
		else $error("bridge powered outside a conversion");
	bridge_brief_a: assert property (bon_q <= 16'(BR_MAX))
		else $error("bridge powered too long");
	conv_bound_a: assert property (dhi_q <= 20'(CV_MAX))
		else $error("conversion end not signalled in time");
	sel_hold_a: assert property (bridge_on_out && $past(bridge_on_out)
		|-> $stable(adc_sel_out))
		else $error("ADC select moved during measurement");
	ack_sync_a: assert property (sclk_idle |-> !$rose(dout_out))
		else $error("output rose without a serial clock edge");
	done_pend_a: assert property (sclk_idle and $fell(dout_out)
		|-> conv_busy_out)
		else $error("output fell with no result pending");
	press_upd_a: assert property ($changed(raw_pressure_value_out)
		|-> $past(conv_busy_out))
		else $error("pressure value changed outside a readout");
	temp_upd_a: assert property ($changed(raw_temperature_value_out)
		|-> $past(conv_busy_out))
		else $error("temperature value changed outside a readout");
endmodule : bsr_top_properties

bind bsr_top bsr_top_properties #(.TICK_DIV(TICK_DIV)) bsr_top_properties_inst (
	.mclk_in, .sys_rst_in, .sclk_in, .din_in, .mod_bit_in, .dout_out,
	.bridge_on_out, .adc_sel_out, .conv_busy_out, .raw_pressure_value_out,
	.raw_temperature_value_out);

/* tb/bsr_host.sv */
// Host model: makes the serial clock and data, samples the output line
`timescale 1ns/10ps
module bsr_host
	import bsr_pkg::*;
(
	output logic      sclk_out, // Serial clock to device
	output logic      din_out,  // Serial data to device
	input  wire logic dout_in   // Serial data from device
);
	// Clock stands low between frames
	initial begin
		sclk_out = 1'b0;
		din_out  = 1'b0;
	end
	// Sample at the fall; device output settles ~3 cycles after the rise
	task automatic pulse(input logic b, output logic seen);
		din_out <= b;
		#160 sclk_out <= 1'b1;
		#160 seen = dout_in;
		sclk_out <= 1'b0;
	endtask : pulse
	task automatic send(input logic [20:0] bits, input int n);
		logic s;
		for (int i = n - 1; i >= 0; i--)
			pulse(bits[i], s);
	endtask : send
	task automatic frame(input logic [3:0] code);
		send({11'h000, 3'b111, code, 3'b000}, FRAME_BITS);
	endtask : frame
	task automatic reset_seq;
		send(RESET_PATTERN, RESET_BITS);
	endtask : reset_seq
	task automatic read(input int first, input logic hold,
		output logic [15:0] w);
		logic s;
		w = 16'h0000;
		for (int i = 1; i <= READ_CLOCKS; i++) begin
			pulse(1'b0, s);
			if (i >= first && i < first + WORD_BITS)
				w = {w[14:0], s};
			if (hold && i == 8)
				#4000;
		end
	endtask : read
endmodule : bsr_host

/* tb/testbench.sv */
// Testbench: directed scenarios for the serial readout block
`timescale 1ns/10ps
module testbench;
	import bsr_pkg::*;
	localparam int unsigned TDIV = 2;
	logic        mclk_in;
	logic        sys_rst_in;
	logic        mod_bit_in;
	logic        mod_high;
	logic        mclk_stop = 1'b0;
	logic        bridge_seen;
	logic        sclk;
	logic        din;
	logic        dout_out;
	logic        bridge_on_out;
	logic        adc_sel_out;
	logic        conv_busy_out;
	logic [15:0] raw_p;
	logic [15:0] raw_t;
	int          errors;
	int          num_checks;

	bsr_top #(.TICK_DIV(TDIV)) bsr_top_inst (
		.mclk_in                   (mclk_in),
		.sys_rst_in                (sys_rst_in),
		.sclk_in                   (sclk),
		.din_in                    (din),
		.mod_bit_in                (mod_bit_in),
		.dout_out                  (dout_out),
		.bridge_on_out             (bridge_on_out),
		.adc_sel_out               (adc_sel_out),
		.conv_busy_out             (conv_busy_out),
		.raw_pressure_value_out    (raw_p),
		.raw_temperature_value_out (raw_t)
	);
	bsr_host bsr_host_inst (
		.sclk_out (sclk),
		.din_out  (din),
		.dout_in  (dout_out)
	);

	initial begin
		mclk_in = 1'b0;
		// Stopping parks the clock low; the half-period grid is kept
		forever #20 if (!mclk_stop || mclk_in) mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		mod_bit_in <= mod_high;
		if (bridge_on_out === 1'b1)
			bridge_seen <= 1'b1;
	end

	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask : check
	task automatic wait_dout(input logic lvl, input int lim);
		for (int n = 0; n < lim && dout_out !== lvl; n++)
			@(posedge mclk_in);
	endtask : wait_dout
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic test_idle;
		check("idle flags", 16'h0000,
			{13'h0000, dout_out, bridge_on_out, conv_busy_out});
		check("idle pressure", 16'h0000, raw_p);
		check("idle temperature", 16'h0000, raw_t);
		mclk_stop = 1'b1;
		#1990 mclk_stop = 1'b0;
		@(posedge mclk_in);
		check("standby resume", 16'h0000,
			{13'h0000, dout_out, bridge_on_out, conv_busy_out});
	endtask : test_idle
	task automatic test_calib;
		logic [3:0]  code [4] = '{SETUP_CAL_A, SETUP_CAL_B,
			SETUP_CAL_C, SETUP_CAL_D};
		logic [15:0] exp [4] = '{CALIB_A_INIT, CALIB_B_INIT,
			CALIB_C_INIT, CALIB_D_INIT};
		logic [15:0] w;
		for (int i = 0; i < 4; i++) begin
			bsr_host_inst.reset_seq();
			bsr_host_inst.frame(code[i]);
			bsr_host_inst.read(1, i[0], w);
			check("calibration word", exp[i], w);
		end
	endtask : test_calib
	task automatic test_conv(input logic temp);
		logic [15:0] w;
		logic [15:0] exp;
		mod_high    <= temp;
		bridge_seen = 1'b0;
		// Modulator held high adds one step on every powered tick
		exp = temp ? 16'(BRIDGE_ON_TICKS * ADC_STEP) : 16'h0000;
		bsr_host_inst.reset_seq();
		bsr_host_inst.frame(temp ? SETUP_TEMP : SETUP_PRESS);
		wait_dout(1'b1, 20);
		check("start acknowledge", 16'h0001, {15'h0000, dout_out});
		bsr_host_inst.send(21'h000000, ACK_CLOCKS);
		wait_dout(1'b0, CONV_TICKS * TDIV + 100);
		check("conversion end", 16'h0000, {15'h0000, dout_out});
		check("ADC select", {15'h0000, temp}, {15'h0000, adc_sel_out});
		check("bridge used", 16'h0001, {15'h0000, bridge_seen});
		check("bridge off", 16'h0000, {15'h0000, bridge_on_out});
		bsr_host_inst.read(2, 1'b1, w);
		check("conversion result", exp, w);
		check("held result", exp, temp ? raw_t : raw_p);
		repeat (8) @(posedge mclk_in);
		check("released", 16'h0000, {15'h0000, conv_busy_out});
		mod_high <= 1'b0;
	endtask : test_conv
	task automatic test_abort;
		bsr_host_inst.reset_seq();
		bsr_host_inst.frame(SETUP_TEMP);
		bsr_host_inst.send(21'h000000, ACK_CLOCKS);
		repeat (200) @(posedge mclk_in);
		bsr_host_inst.reset_seq();
		repeat (8) @(posedge mclk_in);
		check("abort flags", 16'h0000,
			{13'h0000, dout_out, bridge_on_out, conv_busy_out});
	endtask : test_abort
	task automatic test_unknown;
		bsr_host_inst.reset_seq();
		bsr_host_inst.frame(4'h0);
		repeat (40) @(posedge mclk_in);
		check("unknown code", 16'h0000,
			{14'h0000, dout_out, conv_busy_out});
	endtask : test_unknown

	initial begin
		#2_000_000;
		errors++;
		end_of_test();
	end
	initial begin
		errors      = 0;
		num_checks  = 0;
		sys_rst_in  = 1'b1;
		mod_high    = 1'b0;
		bridge_seen = 1'b0;
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		test_idle();
		test_calib();
		test_conv(1'b0);
		test_conv(1'b1);
		test_abort();
		test_unknown();
		test_calib();
		end_of_test();
	end
endmodule : testbench
